// [hw/seec_mem.sv]
// serial memory end of the link
`timescale 1ns/10ps
module seec_mem
    import seec_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYC
) (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // link
    seec_if.mem              link,
    // user side status
    output logic             o_busy,
    output logic             o_status_mode
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [1:0] cs_s_q, sk_s_q, di_s_q;
    logic [1:0] cs_s_d, sk_s_d, di_s_d;
    logic       cs_p_q, sk_p_q, cs_p_d, sk_p_d;
    always_comb begin
        cs_s_d = {cs_s_q[0], link.select};
        sk_s_d = {sk_s_q[0], link.serial_clock};
        di_s_d = {di_s_q[0], link.data_line};
        cs_p_d = cs_s_q[1];
        sk_p_d = sk_s_q[1];
    end
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cs_s_q <= 2'h0;
            sk_s_q <= 2'h0;
            di_s_q <= 2'h3;
            cs_p_q <= 1'b0;
            sk_p_q <= 1'b0;
        end else begin
            cs_s_q <= cs_s_d;
            sk_s_q <= sk_s_d;
            di_s_q <= di_s_d;
            cs_p_q <= cs_p_d;
            sk_p_q <= sk_p_d;
        end
    end
    logic cs, di, sk_rise, cs_fall, cs_rise;
    assign cs      = cs_s_q[1];
    assign di      = di_s_q[1];
    assign sk_rise = sk_s_q[1] & ~sk_p_q;
    assign cs_fall = ~cs_s_q[1] & cs_p_q;
    assign cs_rise = cs_s_q[1] & ~cs_p_q;

    // ************************************************************
    // decoder state
    // ************************************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_HDR  = 5'h02,
        ST_DUMY = 5'h04,
        ST_RDAT = 5'h08,
        ST_WDAT = 5'h10
    } seec_mst_t;
    seec_mst_t   st_q, st_d;
    logic [HDR_W-1:0]  hdr_q, hdr_d;
    logic [DATA_W-1:0] sh_q, sh_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [7:0]  dly_q, dly_d;
    logic        oe_q, oe_d, do_q, do_d;
    logic        pend_q, pend_d;
    logic        ewen_q, ewen_d;
    logic        stat_q, stat_d;
    logic        lowok_q, lowok_d;
    logic        armd_q, armd_d;
    logic [7:0]  lowc_q, lowc_d;
    logic [15:0] prog_q, prog_d;
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic        wr_en;
    logic        wr_all;
    logic [ADDR_W-1:0] wr_a;
    logic [DATA_W-1:0] wr_v;

    function automatic logic is_prog(input logic [HDR_W-1:0] h);
        logic [1:0] sub;
        sub = h[ADDR_W-1 -: 2];
        return (h[HDR_W-1 -: OP_W] == OP_WRITE) || (h[HDR_W-1 -: OP_W] == OP_ERASE)
            || (h[HDR_W-1 -: OP_W] == OP_EXT && (sub == SUB_WRITE_ALL_CMD || sub == SUB_ERASE_ALL_CMD));
    endfunction

    always_comb begin
        st_d = st_q; hdr_d = hdr_q; sh_d = sh_q; cnt_d = cnt_q; dly_d = dly_q;
        oe_d = oe_q; do_d = do_q; pend_d = pend_q; ewen_d = ewen_q; stat_d = stat_q;
        lowok_d = lowok_q; lowc_d = lowc_q; armd_d = armd_q;
        prog_d = (prog_q != 16'h0) ? 16'(prog_q - 16'h1) : prog_q;
        wr_en = 1'b0; wr_all = 1'b0; wr_a = hdr_q[ADDR_W-1:0]; wr_v = sh_q;
        // select low time counter
        if (cs) begin
            lowc_d = 8'h0;
        end else if (lowc_q < 8'(CS_LOW_CYC)) begin
            lowc_d = 8'(lowc_q + 8'h1);
        end else begin
            lowok_d = 1'b1;
        end
        if (!cs) begin
            st_d = ST_IDLE; hdr_d = '0; cnt_d = 5'h0;
            if (!stat_q) begin
                oe_d = 1'b0;
            end
        end
        if (cs_fall) begin
            lowok_d = 1'b0;
            if (pend_q) begin
                pend_d = 1'b0;
                armd_d = 1'b1;
                prog_d = 16'(PROG_CYCLES);
                if (hdr_q[HDR_W-1 -: OP_W] == OP_EXT) begin
                    wr_all = 1'b1;
                    wr_v = (hdr_q[ADDR_W-1 -: 2] == SUB_ERASE_ALL_CMD) ? ERASED : sh_q;
                end else begin
                    wr_v = (hdr_q[HDR_W-1 -: OP_W] == OP_ERASE) ? ERASED : sh_q;
                end
                wr_en = ewen_q;
            end
        end
        // status only follows a programming start, else it fights the next frame
        if (cs_rise && lowok_q && armd_q) begin
            stat_d = 1'b1;
            armd_d = 1'b0;
        end
        if (stat_q) begin
            oe_d = cs;
            do_d = (prog_q == 16'h0);
        end
        if (cs && sk_rise) begin
            case (st_q)
            ST_IDLE: begin
                if (di) begin
                    stat_d = 1'b0;
                    oe_d = 1'b0;
                    st_d = ST_HDR; cnt_d = 5'h0;
                end
            end
            ST_HDR: begin
                hdr_d = {hdr_q[HDR_W-2:0], di};
                cnt_d = 5'(cnt_q + 5'h1);
                if (cnt_q == 5'(HDR_W - 1)) begin
                    cnt_d = 5'h0;
                    if (hdr_q[HDR_W-2 -: OP_W] == OP_READ) begin
                        st_d = ST_DUMY; dly_d = 8'(DUMMY_CYC);
                        sh_d = mem_q[{hdr_q[ADDR_W-2:0], di}];
                    end else if (hdr_q[HDR_W-2 -: OP_W] == OP_WRITE
                              || (hdr_q[HDR_W-2 -: OP_W] == OP_EXT
                                  && hdr_q[ADDR_W-2 -: 2] == SUB_WRITE_ALL_CMD)) begin
                        st_d = ST_WDAT;
                    end else begin
                        st_d = ST_IDLE;
                        if (hdr_q[HDR_W-2 -: OP_W] == OP_EXT) begin
                            if (hdr_q[ADDR_W-2 -: 2] == SUB_EN) ewen_d = 1'b1;
                            if (hdr_q[ADDR_W-2 -: 2] == SUB_DIS) ewen_d = 1'b0;
                        end
                        pend_d = is_prog({hdr_q[HDR_W-2:0], di});
                    end
                end
            end
            ST_WDAT: begin
                sh_d = {sh_q[DATA_W-2:0], di};
                cnt_d = 5'(cnt_q + 5'h1);
                if (cnt_q == 5'(DATA_W - 1)) begin
                    st_d = ST_IDLE; pend_d = 1'b1;
                end
            end
            ST_RDAT: begin
                do_d = sh_q[DATA_W-1];
                sh_d = {sh_q[DATA_W-2:0], 1'b0};
            end
            // clock rises before the dummy bit are ignored
            ST_DUMY: ;
            default: st_d = ST_IDLE;
            endcase
        end
        if (cs && st_q == ST_DUMY) begin
            if (dly_q == 8'h0) begin
                oe_d = 1'b1; do_d = 1'b0;
                st_d = ST_RDAT;
            end else begin
                dly_d = 8'(dly_q - 8'h1);
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= ST_IDLE; hdr_q <= '0; sh_q <= '0; cnt_q <= 5'h0; dly_q <= 8'h0;
            oe_q <= 1'b0; do_q <= 1'b1; pend_q <= 1'b0; ewen_q <= 1'b0;
            stat_q <= 1'b1;
            lowok_q <= 1'b0; lowc_q <= 8'h0; prog_q <= 16'h0;
            armd_q <= 1'b0;
        end else begin
            st_q <= st_d; hdr_q <= hdr_d; sh_q <= sh_d; cnt_q <= cnt_d; dly_q <= dly_d;
            oe_q <= oe_d; do_q <= do_d; pend_q <= pend_d; ewen_q <= ewen_d;
            stat_q <= stat_d; lowok_q <= lowok_d; lowc_q <= lowc_d; prog_q <= prog_d;
            armd_q <= armd_d;
        end
    end
    // memory array, no reset
    always_ff @(posedge i_mclk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (wr_en && (wr_all || wr_a == ADDR_W'(i))) begin
                mem_q[i] <= wr_v;
            end
        end
    end

    assign link.mem_oe   = oe_q;
    assign link.mem_do   = do_q;
    assign o_busy        = (prog_q != 16'h0);
    assign o_status_mode = stat_q;
endmodule

// [common/seec_pkg.sv]
// shared constants and types for the serial memory link
package seec_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ       = 25;
    localparam int CS_LOW_NS     = 1000;
    localparam int CS_LOW_CYC    = (CS_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int DUMMY_NS      = 500;
    localparam int DUMMY_CYC     = (DUMMY_NS * CLK_MHZ) / 1000;
    localparam int SK_HALF_CYC   = 4;
    localparam int PROG_CYC      = 200;
    // ************************************************************
    // frame layout
    // ************************************************************
    localparam int ADDR_W        = 6;
    localparam int DATA_W        = 16;
    localparam int OP_W          = 2;
    localparam int HDR_W         = OP_W + ADDR_W;
    localparam int DEPTH         = 64;
    // ************************************************************
    // opcodes and extended sub codes
    // ************************************************************
    localparam logic [1:0] OP_EXT   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] SUB_DIS  = 2'h0;
    localparam logic [1:0] SUB_WRITE_ALL_CMD = 2'h1;
    localparam logic [1:0] SUB_ERASE_ALL_CMD = 2'h2;
    localparam logic [1:0] SUB_EN   = 2'h3;
    localparam logic [15:0] ERASED  = 16'hFFFF;
    // ************************************************************
    // host command codes
    // ************************************************************
    typedef enum logic [2:0] {
        SEEC_CMD_READ  = 3'h0,
        SEEC_CMD_WRITE = 3'h1,
        SEEC_CMD_ERASE = 3'h2,
        SEEC_CMD_EWEN  = 3'h3,
        SEEC_CMD_EWDS  = 3'h4,
        SEEC_CMD_ERASE_ALL_CMD  = 3'h5,
        SEEC_CMD_WRITE_ALL_CMD  = 3'h6
    } seec_cmd_t;
endpackage

// [common/seec_if.sv]
// three wire link between host and serial memory, shared data line
`timescale 1ns/10ps
interface seec_if;
    logic select;
    logic serial_clock;
    logic host_do;
    logic host_oe;
    logic mem_do;
    logic mem_oe;
    logic data_line;
    // pulled high when nobody drives
    assign data_line = mem_oe ? mem_do : (host_oe ? host_do : 1'b1);
    modport host (output select, output serial_clock, output host_do, output host_oe,
                  input mem_do, input mem_oe, input data_line);
    modport mem (input select, input serial_clock, input host_do, input host_oe,
                 output mem_do, output mem_oe, input data_line);
endinterface

// [hw/seec_host.sv]
// host controller end of the link
`timescale 1ns/10ps
module seec_host
    import seec_pkg::*;
(
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    // command request
    input  wire logic              i_req,
    input  wire seec_cmd_t         i_cmd,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    output logic                   o_ready,
    // answer
    output logic                   o_done,
    output logic [DATA_W-1:0]      o_rdata,
    // link
    seec_if.host                   link
);
    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [6:0] {
        HS_INIT = 7'h01, HS_LOWG = 7'h02, HS_IDLE = 7'h04, HS_SHFT = 7'h08,
        HS_RDAT = 7'h10, HS_WAIT = 7'h20, HS_CANC = 7'h40
    } seec_hst_t;
    seec_hst_t st_q, st_d;
    logic [1:0]  ln_s_q, ln_s_d;
    logic        cs_q, cs_d, sk_q, sk_d, oe_q, oe_d, do_q, do_d, dn_q, dn_d;
    logic [5:0]  bits_q, bits_d;
    logic [7:0]  tm_q, tm_d;
    logic [1+HDR_W+DATA_W-1:0] sh_q, sh_d;
    logic [DATA_W-1:0] rd_q, rd_d;
    logic        rd_op_q, rd_op_d, pg_q, pg_d;
    logic [1:0]  opc;
    logic [ADDR_W-1:0] adr;
    logic        has_data, prog;
    logic        ln;
    assign ln = ln_s_q[1];

    always_comb begin
        opc = OP_EXT; adr = i_addr; has_data = 1'b0; prog = 1'b0;
        case (i_cmd)
        SEEC_CMD_READ:  opc = OP_READ;
        SEEC_CMD_WRITE: begin opc = OP_WRITE; has_data = 1'b1; prog = 1'b1; end
        SEEC_CMD_ERASE: begin opc = OP_ERASE; prog = 1'b1; end
        SEEC_CMD_EWEN:  adr = {SUB_EN, 4'h0};
        SEEC_CMD_EWDS:  adr = {SUB_DIS, 4'h0};
        SEEC_CMD_ERASE_ALL_CMD:  begin adr = {SUB_ERASE_ALL_CMD, 4'h0}; prog = 1'b1; end
        SEEC_CMD_WRITE_ALL_CMD:  begin adr = {SUB_WRITE_ALL_CMD, 4'h0}; has_data = 1'b1; prog = 1'b1; end
        default: ;
        endcase
    end

    always_comb begin
        st_d = st_q; cs_d = cs_q; sk_d = sk_q; oe_d = oe_q; do_d = do_q; dn_d = 1'b0;
        bits_d = bits_q; sh_d = sh_q; rd_d = rd_q; rd_op_d = rd_op_q; pg_d = pg_q;
        ln_s_d = {ln_s_q[0], link.data_line};
        tm_d = (tm_q != 8'h0) ? 8'(tm_q - 8'h1) : tm_q;
        case (st_q)
        HS_INIT: begin
            // select high, one clock to cancel power-up status
            cs_d = 1'b1;
            if (tm_q == 8'h0) begin
                sk_d = ~sk_q;
                tm_d = 8'(SK_HALF_CYC);
                if (sk_q) begin
                    cs_d = 1'b0; tm_d = 8'(CS_LOW_CYC); st_d = HS_LOWG;
                end
            end
        end
        HS_LOWG: begin
            cs_d = 1'b0; sk_d = 1'b0; oe_d = 1'b0;
            if (tm_q == 8'h0) st_d = HS_IDLE;
        end
        HS_IDLE: begin
            if (i_req) begin
                cs_d = 1'b1; oe_d = 1'b1; tm_d = 8'(SK_HALF_CYC);
                sh_d = {1'b1, opc, adr, i_wdata};
                bits_d = has_data ? 6'(1 + HDR_W + DATA_W) : 6'(1 + HDR_W);
                rd_op_d = (i_cmd == SEEC_CMD_READ); pg_d = prog;
                do_d = 1'b1;
            end
        end
        HS_SHFT: begin
            if (tm_q == 8'h0) begin
                tm_d = 8'(SK_HALF_CYC);
                sk_d = ~sk_q;
                if (sk_q) begin
                    // next bit goes out on the falling edge
                    do_d = sh_q[HDR_W+DATA_W-1];
                    sh_d = {sh_q[HDR_W+DATA_W-1:0], 1'b0};
                    bits_d = 6'(bits_q - 6'h1);
                    if (bits_q == 6'h1) begin
                        if (rd_op_q) begin
                            oe_d = 1'b0;
                            bits_d = 6'(DATA_W + 1);
                            // first rise only after the dummy bit stands
                            tm_d = 8'(DUMMY_CYC + SK_HALF_CYC);
                            st_d = HS_RDAT;
                        end else if (pg_q) begin
                            oe_d = 1'b0; cs_d = 1'b0; sk_d = 1'b0;
                            tm_d = 8'(CS_LOW_CYC); st_d = HS_WAIT;
                        end else begin
                            oe_d = 1'b0; cs_d = 1'b0; tm_d = 8'(CS_LOW_CYC);
                            dn_d = 1'b1; st_d = HS_LOWG;
                        end
                    end
                end
            end
        end
        HS_RDAT: begin
            if (tm_q == 8'h0) begin
                tm_d = 8'(SK_HALF_CYC);
                sk_d = ~sk_q;
                if (!sk_q) begin
                    // sample after the previous bit settled, first is dummy
                    if (bits_q != 6'(DATA_W + 1)) rd_d = {rd_q[DATA_W-2:0], ln};
                    bits_d = 6'(bits_q - 6'h1);
                    if (bits_q == 6'h1) begin
                        sk_d = 1'b0; cs_d = 1'b0; dn_d = 1'b1;
                        tm_d = 8'(CS_LOW_CYC); st_d = HS_LOWG;
                    end
                end
            end
        end
        HS_WAIT: begin
            // clock held still until ready is seen
            if (tm_q == 8'h0) begin
                cs_d = 1'b1;
                if (cs_q && ln && link.mem_oe) begin
                    tm_d = 8'(SK_HALF_CYC); st_d = HS_CANC;
                end
            end
            // line read only once the status driver has settled
            if (cs_q && !link.mem_oe) tm_d = 8'(SK_HALF_CYC);
        end
        HS_CANC: begin
            // one clock while the line still reads high
            if (tm_q == 8'h0) begin
                sk_d = ~sk_q; tm_d = 8'(SK_HALF_CYC);
                if (sk_q) begin
                    cs_d = 1'b0; dn_d = 1'b1; tm_d = 8'(CS_LOW_CYC); st_d = HS_LOWG;
                end
            end
        end
        default: st_d = HS_INIT;
        endcase
        if (st_q == HS_IDLE && i_req) st_d = HS_SHFT;
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= HS_INIT; cs_q <= 1'b0; sk_q <= 1'b0; oe_q <= 1'b0; do_q <= 1'b0;
            dn_q <= 1'b0; bits_q <= 6'h0; tm_q <= 8'h0; sh_q <= '0; rd_q <= '0;
            rd_op_q <= 1'b0; pg_q <= 1'b0; ln_s_q <= 2'h3;
        end else begin
            st_q <= st_d; cs_q <= cs_d; sk_q <= sk_d; oe_q <= oe_d; do_q <= do_d;
            dn_q <= dn_d; bits_q <= bits_d; tm_q <= tm_d; sh_q <= sh_d; rd_q <= rd_d;
            rd_op_q <= rd_op_d; pg_q <= pg_d; ln_s_q <= ln_s_d;
        end
    end

    assign o_ready           = (st_q == HS_IDLE);
    assign o_done            = dn_q;
    assign o_rdata           = rd_q;
    assign link.select       = cs_q;
    assign link.serial_clock = sk_q;
    assign link.host_do      = do_q;
    assign link.host_oe      = oe_q;
endmodule

// [bench/seec_monitor.sv]
// concurrent checks on the link joining the host and memory ends
`timescale 1ns/10ps
module seec_monitor
    import seec_pkg::*;
(
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst,
    // link
    input  wire logic select,
    input  wire logic serial_clock,
    input  wire logic host_do,
    input  wire logic host_oe,
    input  wire logic mem_do,
    input  wire logic mem_oe,
    input  wire logic data_line,
    // memory status
    input  wire logic o_busy,
    input  wire logic o_status_mode
);
    // ************************************************************
    // helper logic: edges in frame, header bits, select low time
    // ************************************************************
    logic       sck_q;
    logic       sck_rise;
    logic       lsb_rd;
    logic       shifting;
    logic [4:0] edge_cnt_q;
    logic [4:0] edge_cnt_d;
    logic [7:0] hdr_q;
    logic [7:0] hdr_d;
    logic [5:0] lo_cnt_q;
    logic [5:0] lo_cnt_d;

    always_comb begin
        sck_rise   = serial_clock && !sck_q;
        lsb_rd     = sck_rise && select && (edge_cnt_q == 5'h08) && (hdr_q[6:5] == OP_READ);
        shifting   = select && (edge_cnt_q != 5'h00)
                     && !((edge_cnt_q > 5'h08) && (hdr_q[6:5] == OP_READ));
        edge_cnt_d = edge_cnt_q;
        hdr_d      = hdr_q;
        lo_cnt_d   = (lo_cnt_q == 6'h3F) ? lo_cnt_q : lo_cnt_q + 6'h01;
        if (select) begin
            lo_cnt_d = 6'h00;
        end
        if (!select) begin
            edge_cnt_d = 5'h00;
        end else if (sck_rise && edge_cnt_q != 5'h1F) begin
            edge_cnt_d = edge_cnt_q + 5'h01;
            if (edge_cnt_q < 5'h08) begin
                hdr_d = {hdr_q[6:0], data_line};
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sck_q      <= 1'b0;
            edge_cnt_q <= 5'h00;
            hdr_q      <= 8'h00;
            lo_cnt_q   <= 6'h3F;
        end else begin
            sck_q      <= serial_clock;
            edge_cnt_q <= edge_cnt_d;
            hdr_q      <= hdr_d;
            lo_cnt_q   <= lo_cnt_d;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    sequence seq_float_wait;
        !mem_oe [*8];
    endsequence
    sequence seq_dummy_low;
        ##[1:14] (mem_oe && !mem_do);
    endsequence

    chk_float_shift: assert property (
        shifting && !o_status_mode && !$past(o_status_mode) && !$past(o_status_mode, 2)
        |-> !mem_oe) else $error("memory drives while bits shift in");
    chk_dummy_bit: assert property (
        lsb_rd |-> seq_float_wait ##0 seq_dummy_low)
        else $error("no low dummy bit after read address");
    chk_no_fight: assert property (
        mem_oe |-> !host_oe) else $error("both ends drive the data line");
    chk_prog_start: assert property (
        $rose(o_busy) |-> !select && (lo_cnt_q inside {[6'h01:6'h08]}))
        else $error("programming not started by select fall");
    chk_status_level: assert property (
        mem_oe && o_status_mode && $stable(o_busy) && ($past(o_busy) == $past(o_busy, 2))
        |-> mem_do == !o_busy) else $error("status output wrong level");
    chk_status_cancel: assert property (
        sck_rise && select && data_line && o_status_mode
        |-> ##[1:6] (!o_status_mode && !mem_oe)) else $error("status not cancelled");
    chk_select_gap: assert property (
        $rose(select) |-> lo_cnt_q >= CS_LOW_CYC) else $error("select low too short");
    chk_clock_hold: assert property (
        o_busy |-> $stable(serial_clock)) else $error("clock toggled while programming");
    chk_cancel_high: assert property (
        sck_rise && select && o_status_mode |-> data_line)
        else $error("cancel pulse with data line low");
    chk_power_ready: assert property (
        $fell(i_rst) |-> o_status_mode) else $error("status mode not set after reset");
endmodule

// [bench/testbench.sv]
// self-checking bench: host and memory ends joined by the link
`timescale 1ns/10ps
module testbench;
    import seec_pkg::*;
    logic              i_mclk;
    logic              i_rst;
    logic              i_req;
    seec_cmd_t         i_cmd;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata;
    logic              o_ready;
    logic              o_done;
    logic [DATA_W-1:0] o_rdata;
    logic              o_busy;
    logic              o_status_mode;
    int                fails;
    int                n_compared;
    int                sel_hi;
    logic [31:0]       rng;
    logic              en;
    logic              cur_rd;
    logic              oe_q;
    logic              r;
    logic [DATA_W-1:0] e;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] shadow [DEPTH];
    logic              rd_q [$];
    logic [DATA_W-1:0] exp_q [$];

    seec_if lnk ();
    seec_host seec_host_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req), .i_cmd(i_cmd),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready), .o_done(o_done),
        .o_rdata(o_rdata), .link(lnk.host));
    seec_mem #(.PROG_CYCLES(100)) seec_mem_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .link(lnk.mem), .o_busy(o_busy), .o_status_mode(o_status_mode));
    seec_monitor seec_monitor_inst (.i_mclk(i_mclk), .i_rst(i_rst), .select(lnk.select),
        .serial_clock(lnk.serial_clock), .host_do(lnk.host_do), .host_oe(lnk.host_oe),
        .mem_do(lnk.mem_do), .mem_oe(lnk.mem_oe), .data_line(lnk.data_line),
        .o_busy(o_busy), .o_status_mode(o_status_mode));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
        n_compared++;
        if (seen !== want) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic complete_run();
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        do begin
            @(negedge i_mclk);
            n++;
        end while (s !== 1'b1 && n < 5000);
        if (n >= 5000) fails++;
    endtask

    // one command, expected result noted before the request
    task automatic run_cmd(input seec_cmd_t cmd, input logic [ADDR_W-1:0] ad);
        logic [DATA_W-1:0] d;
        rng = xs(rng);
        d = rng[31:16];
        wait_hi(o_ready);
        rd_q.push_back(cmd == SEEC_CMD_READ);
        exp_q.push_back(shadow[ad]);
        cur_rd = (cmd == SEEC_CMD_READ);
        @(posedge i_mclk);
        i_req   <= 1'b1;
        i_cmd   <= cmd;
        i_addr  <= ad;
        i_wdata <= d;
        @(posedge i_mclk);
        i_req <= 1'b0;
        case (cmd)
            SEEC_CMD_EWEN:  en = 1'b1;
            SEEC_CMD_EWDS:  en = 1'b0;
            SEEC_CMD_WRITE: if (en) shadow[ad] = d;
            SEEC_CMD_ERASE: if (en) shadow[ad] = 16'hFFFF;
            SEEC_CMD_WRITE_ALL_CMD:  if (en) foreach (shadow[i]) shadow[i] = d;
            SEEC_CMD_ERASE_ALL_CMD:  if (en) foreach (shadow[i]) shadow[i] = 16'hFFFF;
            default: ;
        endcase
        wait_hi(o_done);
    endtask

    // ************************************************************
    // result watcher and wire checks
    // ************************************************************
    always @(negedge i_mclk) begin
        sel_hi = (lnk.select === 1'b1) ? sel_hi + 1 : 0;
        if (cur_rd && lnk.mem_oe === 1'b1 && !oe_q && sel_hi > 40) begin
            check({15'h0000, lnk.data_line}, 16'h0000);
        end
        oe_q = (lnk.mem_oe === 1'b1);
        if (o_done === 1'b1) begin
            if (rd_q.size() == 0) begin
                fails++;
            end else begin
                r = rd_q.pop_front();
                e = exp_q.pop_front();
                if (r) check(o_rdata, e);
            end
        end
    end

    // ************************************************************
    // clock, watchdog and main sequence
    // ************************************************************
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    initial begin
        #(40 * 80000);
        fails++;
        complete_run();
    end

    initial begin
        i_rst   = 1'b1;
        i_req   = 1'b0;
        i_cmd   = SEEC_CMD_READ;
        i_addr  = 6'h00;
        i_wdata = 16'h0000;
        rng     = 32'h00001DA0;
        fails = 0;
        n_compared = 0;
        sel_hi = 0;
        en = 1'b0;
        cur_rd = 1'b0;
        oe_q = 1'b0;
        foreach (shadow[i]) shadow[i] = 16'hFFFF;
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            run_cmd(SEEC_CMD_EWEN, 6'h00);
            run_cmd(SEEC_CMD_ERASE_ALL_CMD, 6'h00);
            run_cmd(SEEC_CMD_READ, 6'h3F);
            for (int i = 0; i < 10; i++) begin
                a = (i < 2) ? {6{i[0]}} : rng[5:0];
                run_cmd(SEEC_CMD_WRITE, a);
                run_cmd(SEEC_CMD_READ, a);
            end
            run_cmd(SEEC_CMD_ERASE, a);
            run_cmd(SEEC_CMD_READ, a);
            run_cmd(SEEC_CMD_WRITE_ALL_CMD, 6'h00);
            run_cmd(SEEC_CMD_READ, 6'h00);
            run_cmd(SEEC_CMD_READ, 6'h3F);
            // programming refused once disabled
            run_cmd(SEEC_CMD_EWDS, 6'h00);
            run_cmd(SEEC_CMD_WRITE, a);
            run_cmd(SEEC_CMD_ERASE, 6'h00);
            run_cmd(SEEC_CMD_ERASE_ALL_CMD, 6'h00);
            run_cmd(SEEC_CMD_READ, a);
            run_cmd(SEEC_CMD_READ, 6'h00);
            // reset again at the end of each of the two passes
            @(posedge i_mclk);
            i_rst <= 1'b1;
            repeat (2) @(posedge i_mclk);
            i_rst <= 1'b0;
        end
        complete_run();
    end
endmodule
